// ### rtl/gpl_regs.svh
// Address map, field positions and reset values of the port block.
`ifndef GPL_REGS_SVH
`define GPL_REGS_SVH
`define GPL_ADDR_W 16
`define GPL_DATA_W 8
`define GPL_NPORTS 4
`define GPL_ADDR_P0 16'hff00
`define GPL_ADDR_P1 16'hff01
`define GPL_ADDR_P2 16'hff02
`define GPL_ADDR_P3 16'hff03
`define GPL_ADDR_PIN_SEL 16'hff2f
`define GPL_ADDR_PULL0 16'hff30
`define GPL_ADDR_PULL1 16'hff31
`define GPL_ADDR_PULL3 16'hff33
`define GPL_RST_BYTE 8'h00
`define GPL_CNT_RST 4'h0
`define GPL_CNT_MSB 3
`define GPL_CNT_LSB 0
`define GPL_CNT_MAX 4'h8
`define GPL_PULL0_MASK 8'h7f
`define GPL_PULL1_MASK 8'hff
`define GPL_PULL3_MASK 8'h0f
`define GPL_PORT2_IDX 2
`endif

// ### rtl/gpl_pkg.sv
// Types shared by the port block.
`include "gpl_regs.svh"
package gpl_pkg;
   typedef logic [`GPL_DATA_W-1:0] gpl_byte_t;
   typedef logic [`GPL_ADDR_W-1:0] gpl_addr_t;
   typedef logic [`GPL_CNT_MSB:`GPL_CNT_LSB] gpl_count_t;
   typedef enum logic {gpl_wait_idle, gpl_wait_held} gpl_wait_t;
endpackage : gpl_pkg

// ### rtl/gpl_port_byte.sv
// One 8-bit port: output latch, pin drive and mode-dependent read value.
`timescale 1ns/100ps
`default_nettype none
`include "gpl_regs.svh"
module gpl_port_byte
   import gpl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_wr_en,
   input wire gpl_byte_t i_wdata,
   input wire gpl_byte_t i_dir_in,
   input wire gpl_byte_t i_pins,
   output gpl_byte_t o_latch,
   output gpl_byte_t o_pin_oe,
   output gpl_byte_t o_rd_val
);
   gpl_byte_t latch;
   gpl_byte_t next_latch;

   always_comb begin
      // Loaded in either direction; input pins simply keep the driver off.
      next_latch = i_wr_en ? i_wdata : latch;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         latch <= `GPL_RST_BYTE;
      end else begin
         latch <= next_latch;
      end
   end

   assign o_latch = latch;
   assign o_pin_oe = ~i_dir_in;
   // Per pin: latch when driving, pin level when an input.
   assign o_rd_val = (latch & ~i_dir_in) | (i_pins & i_dir_in);
endmodule : gpl_port_byte
`default_nettype wire

// ### rtl/gpl_port.sv
// Port latches, analog/digital pin select and pull-up option registers.
`timescale 1ns/100ps
`default_nettype none
`include "gpl_regs.svh"
module gpl_port
   import gpl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire gpl_addr_t i_addr,
   input wire logic i_wr,
   input wire gpl_byte_t i_wdata,
   input wire logic i_bit_wr,
   input wire logic [2:0] i_bit_idx,
   input wire logic i_bit_val,
   input wire logic i_rd,
   output logic o_wait,
   output gpl_byte_t o_rdata,
   input wire gpl_byte_t i_port0_dir_in,
   input wire gpl_byte_t i_port1_dir_in,
   input wire gpl_byte_t i_port2_direction,
   input wire gpl_byte_t i_port3_dir_in,
   input wire gpl_byte_t i_port0_pins,
   input wire gpl_byte_t i_port1_pins,
   input wire gpl_byte_t i_port2_pins,
   input wire gpl_byte_t i_port3_pins,
   output gpl_byte_t o_port0_out,
   output gpl_byte_t o_port1_out,
   output gpl_byte_t o_port2_out,
   output gpl_byte_t o_port3_out,
   output gpl_byte_t o_port0_oe,
   output gpl_byte_t o_port1_oe,
   output gpl_byte_t o_port2_oe,
   output gpl_byte_t o_port3_oe,
   output gpl_byte_t o_port0_pullup,
   output gpl_byte_t o_port1_pullup,
   output gpl_byte_t o_port3_pullup,
   output gpl_byte_t o_analog_inputs
);
   gpl_byte_t dir_in [`GPL_NPORTS];
   gpl_byte_t pins [`GPL_NPORTS];
   gpl_byte_t latch [`GPL_NPORTS];
   gpl_byte_t oe_raw [`GPL_NPORTS];
   gpl_byte_t rd_val [`GPL_NPORTS];
   logic [`GPL_NPORTS-1:0] port_wr;
   gpl_addr_t port_addr [`GPL_NPORTS];
   gpl_count_t digital_pin_count;
   gpl_count_t next_digital_pin_count;
   gpl_byte_t pullup_option_port0;
   gpl_byte_t pullup_option_port1;
   gpl_byte_t pullup_option_port3;
   gpl_byte_t next_pull0;
   gpl_byte_t next_pull1;
   gpl_byte_t next_pull3;
   gpl_byte_t digital_mask;
   gpl_byte_t cur_val;
   gpl_byte_t wr_val;
   gpl_byte_t next_rdata;
   gpl_byte_t rdata;
   gpl_wait_t wait_st;
   gpl_wait_t next_wait_st;
   logic any_wr;
   logic sel_hit;
   logic sel_commit;

   assign port_addr[0] = `GPL_ADDR_P0;
   assign port_addr[1] = `GPL_ADDR_P1;
   assign port_addr[2] = `GPL_ADDR_P2;
   assign port_addr[3] = `GPL_ADDR_P3;
   assign dir_in[0] = i_port0_dir_in;
   assign dir_in[1] = i_port1_dir_in;
   assign dir_in[2] = i_port2_direction;
   assign dir_in[3] = i_port3_dir_in;
   assign pins[0] = i_port0_pins;
   assign pins[1] = i_port1_pins;
   assign pins[2] = i_port2_pins;
   assign pins[3] = i_port3_pins;

   // Pins below the count are digital; the rest go to the converter.
   always_comb begin
      for (int k = 0; k < `GPL_DATA_W; k++) begin
         digital_mask[k] = ({1'b0, digital_pin_count} > 5'(k));
      end
   end

   // Current byte value at the addressed location, as a read would see it.
   always_comb begin
      cur_val = `GPL_RST_BYTE;
      for (int p = 0; p < `GPL_NPORTS; p++) begin
         if (i_addr == port_addr[p]) begin
            cur_val = rd_val[p];
         end
      end
      case (i_addr)
         `GPL_ADDR_PIN_SEL: cur_val = gpl_byte_t'(digital_pin_count);
         `GPL_ADDR_PULL0: cur_val = pullup_option_port0 & `GPL_PULL0_MASK;
         `GPL_ADDR_PULL1: cur_val = pullup_option_port1 & `GPL_PULL1_MASK;
         `GPL_ADDR_PULL3: cur_val = pullup_option_port3 & `GPL_PULL3_MASK;
         default: cur_val = cur_val;
      endcase
   end

   // A bit instruction rewrites the whole byte from the read value, so an
   // input pin's latch takes whatever level the pin had at that moment.
   always_comb begin
      wr_val = i_wdata;
      if (i_bit_wr) begin
         wr_val = cur_val;
         wr_val[i_bit_idx] = i_bit_val;
      end
   end

   assign any_wr = i_wr | i_bit_wr;
   assign sel_hit = any_wr && (i_addr == `GPL_ADDR_PIN_SEL);

   // The select write is held off for one cycle; the CPU keeps the
   // request up while o_wait is high.
   always_comb begin
      next_wait_st = gpl_wait_idle;
      sel_commit = 1'b0;
      case (wait_st)
         gpl_wait_idle: begin
            if (sel_hit) begin
               next_wait_st = gpl_wait_held;
            end
         end
         gpl_wait_held: begin
            sel_commit = sel_hit;
         end
         default: next_wait_st = gpl_wait_idle;
      endcase
   end
   assign o_wait = sel_hit && (wait_st == gpl_wait_idle);

   always_comb begin
      next_digital_pin_count = digital_pin_count;
      next_pull0 = pullup_option_port0;
      next_pull1 = pullup_option_port1;
      next_pull3 = pullup_option_port3;
      if (sel_commit) begin
         next_digital_pin_count = wr_val[`GPL_CNT_MSB:`GPL_CNT_LSB];
      end
      if (any_wr) begin
         case (i_addr)
            `GPL_ADDR_PULL0: begin
               next_pull0 = wr_val & `GPL_PULL0_MASK;
            end
            `GPL_ADDR_PULL1: next_pull1 = wr_val & `GPL_PULL1_MASK;
            `GPL_ADDR_PULL3: next_pull3 = wr_val & `GPL_PULL3_MASK;
            default: next_pull0 = next_pull0;
         endcase
      end
      next_rdata = i_rd ? cur_val : rdata;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         digital_pin_count <= `GPL_CNT_RST;
         pullup_option_port0 <= `GPL_RST_BYTE;
         pullup_option_port1 <= `GPL_RST_BYTE;
         pullup_option_port3 <= `GPL_RST_BYTE;
         rdata <= `GPL_RST_BYTE;
         wait_st <= gpl_wait_idle;
      end else begin
         digital_pin_count <= next_digital_pin_count;
         pullup_option_port0 <= next_pull0;
         pullup_option_port1 <= next_pull1;
         pullup_option_port3 <= next_pull3;
         rdata <= next_rdata;
         wait_st <= next_wait_st;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `GPL_NPORTS; g++) begin : g_port
         assign port_wr[g] = any_wr && (i_addr == port_addr[g]);
         gpl_port_byte u_byte (
            .i_mclk(i_mclk),
            .i_rst_b(i_rst_b),
            .i_wr_en(port_wr[g]),
            .i_wdata(wr_val),
            .i_dir_in(dir_in[g]),
            .i_pins(pins[g]),
            .o_latch(latch[g]),
            .o_pin_oe(oe_raw[g]),
            .o_rd_val(rd_val[g])
         );
      end
   endgenerate

   assign o_rdata = rdata;
   assign o_port0_out = latch[0];
   assign o_port1_out = latch[1];
   assign o_port2_out = latch[2];
   assign o_port3_out = latch[3];
   assign o_port0_oe = oe_raw[0];
   assign o_port1_oe = oe_raw[1];
   // An analog pin never drives, whatever its direction bit says.
   assign o_port2_oe = oe_raw[`GPL_PORT2_IDX] & digital_mask;
   assign o_port3_oe = oe_raw[3];
   assign o_analog_inputs = ~digital_mask;
   assign o_port0_pullup = pullup_option_port0 & i_port0_dir_in;
   assign o_port1_pullup = pullup_option_port1 & i_port1_dir_in;
   assign o_port3_pullup = pullup_option_port3 & i_port3_dir_in;
endmodule : gpl_port
`default_nettype wire

// ### verification/gpl_port_monitor.sv
// Checker on the ports of the port block.
`timescale 1ns/100ps
`default_nettype none
module gpl_port_monitor
   import gpl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire gpl_addr_t i_addr,
   input wire logic i_wr,
   input wire logic i_bit_wr,
   input wire logic i_rd,
   input wire gpl_byte_t i_wdata,
   input wire logic o_wait,
   input wire gpl_byte_t o_rdata,
   input wire gpl_byte_t i_port1_dir_in,
   input wire gpl_byte_t i_port1_pins,
   input wire gpl_byte_t i_port2_direction,
   input wire gpl_byte_t o_port0_out,
   input wire gpl_byte_t o_port1_out,
   input wire gpl_byte_t o_port1_oe,
   input wire gpl_byte_t o_port2_oe,
   input wire gpl_byte_t o_analog_inputs
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   a_wait_cause: assert property (o_wait |->
      (i_wr || i_bit_wr) && i_addr == 16'hff2f) else $error("stray wait");
   a_wait_once: assert property (o_wait |=> !o_wait)
      else $error("wait too long");
   a_latch_load: assert property (i_wr && i_addr == 16'hff01 |=>
      o_port1_out == $past(i_wdata)) else $error("latch not loaded");
   a_latch_hold: assert property (!i_wr && !i_bit_wr |=>
      $stable(o_port0_out)) else $error("latch changed");
   a_reset_clear: assert property (disable iff (1'b0) !i_rst_b |=>
      o_port0_out == 8'h00 && o_port1_out == 8'h00) else $error("no clear");
   a_drive_dir: assert property (o_port1_oe == ~i_port1_dir_in)
      else $error("driver wrong");
   a_analog_off: assert property (o_port2_oe ==
      (~i_port2_direction & ~o_analog_inputs)) else $error("analog driven");
   a_read_mode: assert property (i_rd && !i_wr && i_addr == 16'hff01 |=>
      o_rdata == (($past(i_port1_dir_in) & $past(i_port1_pins)) |
      (~$past(i_port1_dir_in) & $past(o_port1_out)))) else $error("bad read");
   a_rd_hold: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved");
endmodule : gpl_port_monitor
bind gpl_port gpl_port_monitor mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wr(i_wr), .i_bit_wr(i_bit_wr), .i_rd(i_rd),
   .i_wdata(i_wdata), .o_wait(o_wait), .o_rdata(o_rdata),
   .i_port1_dir_in(i_port1_dir_in), .i_port1_pins(i_port1_pins),
   .i_port2_direction(i_port2_direction), .o_port0_out(o_port0_out),
   .o_port1_out(o_port1_out), .o_port1_oe(o_port1_oe),
   .o_port2_oe(o_port2_oe), .o_analog_inputs(o_analog_inputs));
`default_nettype wire

// ### verification/gpl_pins_model.sv
// Board circuitry on one port: driven bits, pull-ups and outside levels.
`timescale 1ns/100ps
`default_nettype none
module gpl_pins_model
   import gpl_pkg::*;
(
   input wire gpl_byte_t i_out,
   input wire gpl_byte_t i_oe,
   input wire gpl_byte_t i_pu,
   input wire gpl_byte_t i_ext,
   output gpl_byte_t o_pins
);
   // An undriven bit shows the outside level unless its pull-up holds it.
   assign o_pins = (i_oe & i_out) | (~i_oe & (i_pu | i_ext));
endmodule : gpl_pins_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the port block.
`timescale 1ns/100ps
`default_nettype none
module tb
   import gpl_pkg::*;
;
   logic i_mclk = 0, i_rst_b = 0, i_wr = 0, i_bit_wr = 0, i_rd = 0;
   logic i_bit_val = 0;
   logic [2:0] i_bit_idx = '0;
   gpl_addr_t i_addr = '0;
   gpl_byte_t i_wdata = '0, d, e;
   // Port 2 starts as input so no analog pin is ever driven.
   gpl_byte_t dir [4] = '{default: 8'hff}, ext [4] = '{default: 8'h00};
   gpl_byte_t lat [4] = '{default: 8'h00}, pu [4] = '{default: 8'h00};
   wire gpl_byte_t out [4], oe [4], pins [4], pull [4];
   wire o_wait;
   wire gpl_byte_t o_rdata, o_analog_inputs;
   int n_errors = 0, checks_done = 0, seed = 32'hb27a, p, bw;
   logic [3:0] b;
   assign pull[2] = 8'h00;
   initial forever #2.5 i_mclk = ~i_mclk;
   for (genvar k = 0; k < 4; k++) begin : g_pin
      gpl_pins_model pm (.i_out(out[k]), .i_oe(oe[k]), .i_pu(pull[k]),
         .i_ext(ext[k]), .o_pins(pins[k]));
   end
   gpl_port uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wr(i_wr), .i_wdata(i_wdata), .i_bit_wr(i_bit_wr),
      .i_bit_idx(i_bit_idx), .i_bit_val(i_bit_val), .i_rd(i_rd),
      .o_wait(o_wait), .o_rdata(o_rdata), .i_port0_dir_in(dir[0]),
      .i_port1_dir_in(dir[1]), .i_port2_direction(dir[2]),
      .i_port3_dir_in(dir[3]), .i_port0_pins(pins[0]),
      .i_port1_pins(pins[1]), .i_port2_pins(pins[2]),
      .i_port3_pins(pins[3]), .o_port0_out(out[0]), .o_port1_out(out[1]),
      .o_port2_out(out[2]), .o_port3_out(out[3]), .o_port0_oe(oe[0]),
      .o_port1_oe(oe[1]), .o_port2_oe(oe[2]), .o_port3_oe(oe[3]),
      .o_port0_pullup(pull[0]), .o_port1_pullup(pull[1]),
      .o_port3_pullup(pull[3]), .o_analog_inputs(o_analog_inputs));
   function automatic gpl_byte_t erd(int q);
      return (dir[q] & (pu[q] | ext[q])) | (~dir[q] & lat[q]);
   endfunction : erd
   task automatic chk(string name, gpl_byte_t seen, gpl_byte_t exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(gpl_addr_t a, logic bit_op, gpl_byte_t v, logic [3:0] bv);
      @(negedge i_mclk);
      i_addr = a;
      i_wdata = v;
      {i_bit_val, i_bit_idx} = bv;
      i_wr = !bit_op;
      i_bit_wr = bit_op;
      if (a == 16'hff2f) begin
         // The wait is combinational; let it settle before looking.
         #1;
         chk("wait", {7'h00, o_wait}, 8'h01);
         @(negedge i_mclk);
         chk("wait", {7'h00, o_wait}, 8'h00);
      end
      @(negedge i_mclk);
      i_wr = 0;
      i_bit_wr = 0;
   endtask : wr
   task automatic rd(gpl_addr_t a, gpl_byte_t exp);
      @(negedge i_mclk);
      i_addr = a;
      i_rd = 1;
      @(negedge i_mclk);
      i_rd = 0;
      chk("rdata", o_rdata, exp);
   endtask : rd
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (30000) @(posedge i_mclk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (10) @(negedge i_mclk);
      i_rst_b = 1;
      chk("analog", o_analog_inputs, 8'hff);
      foreach (lat[q]) rd(16'hff00 + q[15:0], 8'h00);
      // The clock never stops, so every select write is legal.
      // Every count from 0 to 8 is written, from all pins analog to all digital.
      for (int n = 0; n <= 8; n++) begin
         wr(16'hff2f, 0, n[7:0], 4'h0);
         chk("analog", o_analog_inputs, gpl_byte_t'(9'h1ff << n));
         rd(16'hff2f, n[7:0]);
      end
      wr(16'hff2f, 0, 8'h00, 4'h0);
      wr(16'hff2f, 1, 8'h00, 4'hb);
      chk("analog", o_analog_inputs, 8'h00);
      repeat (60) begin
         p = {$random(seed)} % 4;
         dir[p] = 8'($random(seed));
         ext[p] = 8'($random(seed));
         d = 8'($random(seed));
         bw = {$random(seed)} % 2;
         b = 4'($random(seed));
         e = bw ? erd(p) : d;
         if (bw) e[b[2:0]] = b[3];
         wr(16'hff00 + p[15:0], bw[0], d, b);
         lat[p] = e;
         chk("latch", out[p], lat[p]);
         chk("drive", oe[p], ~dir[p]);
         rd(16'hff00 + p[15:0], erd(p));
      end
      for (int q = 0; q < 4; q++) begin
         if (q == 2) continue;
         e = q == 0 ? 8'h7f : (q == 1 ? 8'hff : 8'h0f);
         wr(16'hff30 + q[15:0], 0, 8'hff, 4'h0);
         pu[q] = e;
         rd(16'hff30 + q[15:0], e);
         chk("pullup", pull[q], e & dir[q]);
         rd(16'hff00 + q[15:0], erd(q));
      end
      // Low four pins digital and driven, upper four analog inputs.
      dir[2] = 8'hf0;
      wr(16'hff2f, 0, 8'h04, 4'h0);
      chk("analog", o_analog_inputs, 8'hf0);
      chk("drive", oe[2], 8'h0f);
      wr(16'hff10, 0, 8'h5a, 4'h0);
      rd(16'hff10, 8'h00);
      i_rst_b = 0;
      @(negedge i_mclk);
      i_rst_b = 1;
      foreach (lat[q]) chk("latch", out[q], 8'h00);
      chk("analog", o_analog_inputs, 8'hff);
      conclude();
   end
endmodule : tb
`default_nettype wire
